/* src/lnbc_top.sv */
// serial target, control registers and fault alert of the feed regulator
`timescale 1ns/1ns
`default_nettype none
module lnbc_top (
    input  wire logic                CLOCK,
    input  wire logic                RST,
    input  wire logic                SCL_IN,
    input  wire logic                SDA_IN,
    output var  logic                SDA_OUT,
    output var  logic                SDA_OE,
    input  wire logic [1:0]          ADDR_STRAP,
    input  wire logic                ENABLE_PIN,
    input  wire logic                LEVEL_SELECT_PIN,
    input  wire logic                TONE_ACTIVE,
    input  wire logic                DETECT_TONE_IN,
    input  wire lnbc_pkg::lnbc_diag_t DIAG_IN,
    output var  lnbc_pkg::lnbc_core_t CORE_OUT,
    output var  logic                DETECT_OUT,
    output var  logic                FAULT_OUT,
    output var  logic                FAULT_OE
);
    import lnbc_pkg::*;

    // two-stage synchronisers for every pin
    logic [1:0] scl_s_q, sda_s_q, en_s_q, lvl_s_q, tone_s_q, det_s_q;
    logic [1:0] strap0_s_q, strap1_s_q;
    logic [6:0] diag0_s_q, diag1_s_q;
    logic       scl_prev_q, sda_prev_q;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            scl_s_q    <= 2'h3;
            sda_s_q    <= 2'h3;
            en_s_q     <= 2'h0;
            lvl_s_q    <= 2'h0;
            tone_s_q   <= 2'h0;
            det_s_q    <= 2'h0;
            strap0_s_q <= 2'h0;
            strap1_s_q <= 2'h0;
            diag0_s_q  <= 7'h00;
            diag1_s_q  <= 7'h00;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_s_q    <= {scl_s_q[0], SCL_IN};
            sda_s_q    <= {sda_s_q[0], SDA_IN};
            en_s_q     <= {en_s_q[0], ENABLE_PIN};
            lvl_s_q    <= {lvl_s_q[0], LEVEL_SELECT_PIN};
            tone_s_q   <= {tone_s_q[0], TONE_ACTIVE};
            det_s_q    <= {det_s_q[0], DETECT_TONE_IN};
            strap0_s_q <= {strap0_s_q[0], ADDR_STRAP[0]};
            strap1_s_q <= {strap1_s_q[0], ADDR_STRAP[1]};
            diag0_s_q  <= DIAG_IN;
            diag1_s_q  <= diag0_s_q;
            scl_prev_q <= scl_s_q[1];
            sda_prev_q <= sda_s_q[1];
        end
    end

    // bus events seen on the sampled lines; one clock is ample at 400 kbps
    wire        scl      = scl_s_q[1];
    wire        sda      = sda_s_q[1];
    wire        scl_rise = scl & ~scl_prev_q;
    wire        scl_fall = ~scl & scl_prev_q;
    wire        start_ev = scl & scl_prev_q & ~sda & sda_prev_q;
    wire        stop_ev  = scl & scl_prev_q & sda & ~sda_prev_q;
    lnbc_diag_t diag;
    assign diag = lnbc_diag_t'(diag1_s_q);

    // strap address, followed until the first bus start and held after it;
    // the synchroniser leaves reset at zero, so a latch on the first edge would read a stale code
    logic [6:0] own_addr_q;
    logic       strap_done_q;
    wire  [1:0] strap_code = {strap1_s_q[1], strap0_s_q[1]};
    wire  [6:0] strap_addr = (strap_code == STRAP_SUPPLY) ? ADDR_STRAP_SUPPLY :
                             (strap_code == STRAP_OPEN)   ? ADDR_STRAP_OPEN :
                             (strap_code == STRAP_GROUND) ? ADDR_STRAP_GROUND :
                                                            ADDR_STRAP_DIVIDER;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            own_addr_q   <= ADDR_STRAP_SUPPLY;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            own_addr_q   <= strap_addr;
            strap_done_q <= start_ev;                  // strap settled long before any start
        end
    end

    // serial engine registers
    lnbc_state_t state_q, state_d;
    logic [7:0]  shift_q, shift_d;
    logic [3:0]  bitcnt_q, bitcnt_d;
    logic [7:0]  index_q, index_d;
    logic        is_read_q, is_read_d;
    logic        ack_next_q, ack_next_d;   // which byte the ack follows
    logic        sda_low_q, sda_low_d;
    logic [7:0]  ctrl_one_q, ctrl_two_q;
    logic        wr_one, wr_two, status_read;

    // address match: 7-bit only; general call and 10-bit prefixes never equal a strap value
    wire [7:0] shifted   = {shift_q[6:0], sda};
    // at the eighth low edge the whole byte already sits in the shift register
    wire       addr_hit  = (shift_q[7:1] == own_addr_q);
    wire       byte_done = scl_fall & (bitcnt_q == 4'h8);

    // status byte: live flags, alerted faults shown as latched
    logic       fault_lat_q;
    logic [1:0] fault_src_q;
    wire  [7:0] status_val = {1'b0, diag.tone_good, diag.ldo_on, diag.hot_125,
                              diag.thermal_shutdown_flag | fault_src_q[1],
                              diag.overcurrent_flag | fault_src_q[0],
                              diag.cable_good, diag.vout_good};
    wire  [7:0] read_val   = (index_q == REG_CTRL_ONE) ? ctrl_one_q :
                             (index_q == REG_CTRL_TWO) ? ctrl_two_q :
                             (index_q == REG_STATUS)   ? status_val : 8'h00;

    // next-state logic of the serial target
    always_comb begin
        state_d    = state_q;
        shift_d    = shift_q;
        bitcnt_d   = bitcnt_q;
        index_d    = index_q;
        is_read_d  = is_read_q;
        ack_next_d = ack_next_q;
        sda_low_d  = sda_low_q;
        if (start_ev) begin
            state_d   = ST_ADDR;                       // repeated start too
            bitcnt_d  = 4'h0;
            sda_low_d = 1'b0;
        end else if (stop_ev) begin
            state_d   = ST_IDLE;
            sda_low_d = 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_INDEX, ST_DATA: begin
                    if (scl_rise) begin
                        shift_d  = shifted;
                        bitcnt_d = bitcnt_q + 4'h1;
                    end else if (byte_done) begin
                        bitcnt_d = 4'h0;
                        if (state_q == ST_ADDR && !addr_hit) begin
                            state_d = ST_IDLE;         // not ours, stay silent
                        end else begin
                            if (state_q == ST_ADDR) begin
                                is_read_d = shift_q[0];
                            end
                            if (state_q == ST_INDEX) begin
                                index_d = shift_q;
                            end
                            ack_next_d = (state_q == ST_ADDR) ? 1'b0 : 1'b1;
                            sda_low_d  = 1'b1;
                            state_d    = ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    // held through the ninth high phase, let go on its falling edge
                    if (scl_fall) begin
                        if (!ack_next_q && is_read_q) begin
                            state_d   = ST_READ;
                            shift_d   = read_val;
                            sda_low_d = ~read_val[7];
                            bitcnt_d  = 4'h1;
                        end else begin
                            sda_low_d = 1'b0;
                            state_d   = ack_next_q ? ST_DATA : ST_INDEX;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        if (bitcnt_q == 4'h8) begin
                            sda_low_d = 1'b0;
                            state_d   = ST_RACK;
                        end else begin
                            shift_d   = {shift_q[6:0], 1'b0};
                            sda_low_d = ~shift_q[6];
                            bitcnt_d  = bitcnt_q + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    // controller nacks the single byte, then stops
                    if (scl_rise) begin
                        state_d = ST_IDLE;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    // commit on the falling edge after the data lsb, held off while pin disabled
    wire data_commit = (state_q == ST_DATA) & byte_done & ~is_read_q;
    wire pin_enabled = en_s_q[1];
    assign wr_one = data_commit & pin_enabled & (index_q == REG_CTRL_ONE);
    assign wr_two = data_commit & pin_enabled & (index_q == REG_CTRL_TWO);
    // status taken as read once its byte has been shifted out
    assign status_read = (state_q == ST_READ) & scl_fall & (bitcnt_q == 4'h8) &
                         (index_q == REG_STATUS);

    // serial engine state
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_q    <= ST_IDLE;
            shift_q    <= 8'h00;
            bitcnt_q   <= 4'h0;
            index_q    <= 8'h00;
            is_read_q  <= 1'b0;
            ack_next_q <= 1'b0;
            sda_low_q  <= 1'b0;
        end else begin
            state_q    <= state_d;
            shift_q    <= shift_d;
            bitcnt_q   <= bitcnt_d;
            index_q    <= index_d;
            is_read_q  <= is_read_d;
            ack_next_q <= ack_next_d;
            sda_low_q  <= sda_low_d;
        end
    end

    // control registers; status index is read only, writes there dropped
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ctrl_one_q <= CTRL_ONE_RESET;
            ctrl_two_q <= CTRL_TWO_RESET;
        end else begin
            if (wr_one) begin
                ctrl_one_q <= shift_q;
            end
            if (wr_two) begin
                ctrl_two_q <= shift_q;
            end
        end
    end

    // fault alert: a new fault wins over a status read in the same cycle
    wire [1:0] fault_now = {diag.thermal_shutdown_flag, diag.overcurrent_flag};
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            fault_lat_q <= 1'b0;
            fault_src_q <= 2'h0;
        end else if (|fault_now) begin
            fault_lat_q <= 1'b1;
            fault_src_q <= fault_src_q | fault_now;
        end else if (status_read) begin
            fault_lat_q <= 1'b0;
            fault_src_q <= 2'h0;
        end
    end

    // core controls: host bit overrides pin path for level and enable
    wire        host_ctrl  = ctrl_one_q[C1_HOST_CTRL];
    wire [3:0]  pin_level  = lvl_s_q[1] ? PIN_LEVEL_HIGH : PIN_LEVEL_LOW;
    wire [3:0]  level_sel  = host_ctrl ? ctrl_one_q[C1_LEVEL_HI:C1_LEVEL_LO] : pin_level;
    wire        enable_sel = host_ctrl ? ctrl_two_q[C2_OUT_EN] : pin_enabled;
    wire        gate_sel   = ctrl_two_q[C2_BYP_AUTO] ? tone_s_q[1]
                                                     : ctrl_two_q[C2_BYP_XMIT];
    lnbc_core_t core_d;
    assign core_d = '{light_load_mode:        ctrl_one_q[C1_LIGHT_LOAD],
                      output_level_code:      level_sel,
                      wide_tone_input_select: ctrl_one_q[C1_WIDE_TONE],
                      tone_amplitude_select:  ctrl_two_q[C2_TONE_AMP],
                      hiccup_long_select:     ctrl_two_q[C2_HICCUP],
                      switch_limit_scale:     ctrl_two_q[C2_SW_LIMIT],
                      switching_rate_select:  ctrl_two_q[C2_SW_RATE],
                      feed_enable:            enable_sel,
                      bypass_gate_drive:      gate_sel};

    // registered outputs; open-drain pins only ever drive low
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            CORE_OUT   <= '0;
            DETECT_OUT <= 1'b1;
            FAULT_OUT  <= 1'b0;
            FAULT_OE   <= 1'b0;
            SDA_OUT    <= 1'b0;
            SDA_OE     <= 1'b0;
        end else begin
            CORE_OUT   <= core_d;
            // detect mode bit is reserved; only the zero behaviour exists
            DETECT_OUT <= ~det_s_q[1];
            FAULT_OUT  <= 1'b0;
            FAULT_OE   <= fault_lat_q;
            SDA_OUT    <= 1'b0;
            SDA_OE     <= sda_low_q;
        end
    end

endmodule
`default_nettype wire

/* src/lnbc_pkg.sv */
// package of constants and carrier types for the feed regulator serial control block
package lnbc_pkg;

    // register indices
    localparam logic [7:0] REG_CTRL_ONE = 8'h00;
    localparam logic [7:0] REG_CTRL_TWO = 8'h01;
    localparam logic [7:0] REG_STATUS   = 8'h02;

    // reset values
    localparam logic [7:0] CTRL_ONE_RESET = 8'h08;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h09;

    // strap coded target addresses
    localparam logic [6:0] ADDR_STRAP_SUPPLY  = 7'h08;
    localparam logic [6:0] ADDR_STRAP_OPEN    = 7'h09;
    localparam logic [6:0] ADDR_STRAP_GROUND  = 7'h10;
    localparam logic [6:0] ADDR_STRAP_DIVIDER = 7'h11;

    // strap level codes from the analog comparator
    localparam logic [1:0] STRAP_SUPPLY  = 2'h0;
    localparam logic [1:0] STRAP_OPEN    = 2'h1;
    localparam logic [1:0] STRAP_GROUND  = 2'h2;
    localparam logic [1:0] STRAP_DIVIDER = 2'h3;

    // control one field positions
    localparam int C1_HOST_CTRL  = 7;
    localparam int C1_LIGHT_LOAD = 6;
    localparam int C1_LEVEL_HI   = 4;
    localparam int C1_LEVEL_LO   = 1;
    localparam int C1_WIDE_TONE  = 0;

    // control two field positions
    localparam int C2_TONE_AMP   = 7;
    localparam int C2_HICCUP     = 6;
    localparam int C2_SW_LIMIT   = 5;
    localparam int C2_SW_RATE    = 4;
    localparam int C2_OUT_EN     = 3;
    localparam int C2_DET_MODE   = 2;
    localparam int C2_BYP_AUTO   = 1;
    localparam int C2_BYP_XMIT   = 0;

    // status field positions
    localparam int ST_THERMAL    = 3;
    localparam int ST_OVERCUR    = 2;

    // output level code the pin path uses when the level select pin is low or high
    localparam logic [3:0] PIN_LEVEL_LOW  = 4'h4;
    localparam logic [3:0] PIN_LEVEL_HIGH = 4'hC;

    // serial engine states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_ACK   = 3'b010,
        ST_INDEX = 3'b011,
        ST_DATA  = 3'b100,
        ST_READ  = 3'b101,
        ST_RACK  = 3'b110
    } lnbc_state_t;

    // analog control word toward the regulator core
    typedef struct packed {
        logic       light_load_mode;
        logic [3:0] output_level_code;
        logic       wide_tone_input_select;
        logic       tone_amplitude_select;
        logic       hiccup_long_select;
        logic       switch_limit_scale;
        logic       switching_rate_select;
        logic       feed_enable;
        logic       bypass_gate_drive;
    } lnbc_core_t;

    // raw fault and diagnostic conditions from the analog side
    typedef struct packed {
        logic tone_good;
        logic ldo_on;
        logic hot_125;
        logic thermal_shutdown_flag;
        logic overcurrent_flag;
        logic cable_good;
        logic vout_good;
    } lnbc_diag_t;

endpackage

/* tb/lnbc_top_sva.sv */
// assertions on the serial target, control outputs and fault alert
`timescale 1ns/1ns
`default_nettype none
module lnbc_top_sva (
    input wire logic                 CLOCK,
    input wire logic                 RST,
    input wire logic                 SCL_IN,
    input wire logic                 SDA_OUT,
    input wire logic                 SDA_OE,
    input wire logic                 DETECT_TONE_IN,
    input wire logic                 DETECT_OUT,
    input wire lnbc_pkg::lnbc_diag_t DIAG_IN,
    input wire lnbc_pkg::lnbc_core_t CORE_OUT,
    input wire logic                 FAULT_OUT,
    input wire logic                 FAULT_OE
);
    import lnbc_pkg::*;
    logic [7:0] age_q;
    logic [3:0] hi_q;
    wire  logic [5:0] fields = {CORE_OUT[11], CORE_OUT[6:2]};
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    // cycles since data was last pulled low, and how long the bus clock stood high
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            age_q <= 8'hFF;
            hi_q <= 4'h0;
        end else begin
            age_q <= SDA_OE ? 8'h00 : age_q + {7'h00, age_q != 8'hFF};
            hi_q <= SCL_IN ? hi_q + {3'h0, hi_q != 4'hF} : 4'h0;
        end
    end
    // raw pins lead the synchronised view, so windows allow a few clocks
    sequence s_held;
        SDA_OE [*4];
    endsequence
    sequence s_fault;
        (DIAG_IN.thermal_shutdown_flag || DIAG_IN.overcurrent_flag) [*6];
    endsequence
    a_drive_low: assert property (SDA_OE |-> !SDA_OUT)
        else $error("data line driven high");
    a_ack_moves: assert property ($changed(SDA_OE) |-> !SCL_IN)
        else $error("data line moved while clock high");
    a_ack_held: assert property ($rose(SCL_IN) && SDA_OE |=> s_held)
        else $error("acknowledge dropped early");
    a_field_commit: assert property ($changed(fields) |-> !SCL_IN)
        else $error("field changed outside clock low");
    a_alert_low: assert property (FAULT_OE |-> !FAULT_OUT)
        else $error("alert driven high");
    a_fault_set: assert property (s_fault |-> FAULT_OE)
        else $error("alert missing");
    a_alert_kept: assert property (FAULT_OE && hi_q == 4'hF |=> FAULT_OE)
        else $error("alert released while bus idle");
    a_fault_release: assert property ($fell(FAULT_OE) |-> age_q < 8'h96)
        else $error("alert released without a read");
    a_detect_low: assert property (DETECT_TONE_IN [*5] |-> !DETECT_OUT)
        else $error("detect not low with tone");
    a_detect_high: assert property ((!DETECT_TONE_IN) [*5] |-> DETECT_OUT)
        else $error("detect low without tone");
endmodule
`default_nettype wire

/* tb/lnbc_host.sv */
// two-wire bus controller model facing the serial target
`timescale 1ns/1ns
`default_nettype none
module lnbc_host (
    output var logic scl,
    output var logic sda_drv,
    input  wire logic sda
);
    logic [7:0] rd;
    int         slow = 0;
    event       got;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // data moves well after the low edge so it never looks like a start or stop
    task automatic bit_io(input logic v, output logic s);
        #20 sda_drv = v;
        #(42 + slow) scl = 1'b1;
        #30 s = sda;
        #33 scl = 1'b0;
    endtask
    // start when st is high, stop otherwise
    task automatic cond(input logic st);
        #20 sda_drv = st;
        #42 scl = 1'b1;
        #63 sda_drv = !st;
        #65 scl = !st;
    endtask
    // msb first, then the ninth bit: acknowledge sampled, or none given on a read
    task automatic byt(input logic [7:0] b, input logic rx);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i] | rx, s);
            rd[i] = s;
        end
        bit_io(1'b1, s);
        rd = rx ? rd : {7'h00, s};
        ->got;
    endtask
endmodule
`default_nettype wire

/* tb/lnbc_top_test.sv */
// self-checking bench for the feed regulator serial control block
`timescale 1ns/1ns
`default_nettype none
module lnbc_top_test;
    import lnbc_pkg::*;
    logic        CLOCK = 1'b0;
    logic        RST = 1'b1;
    logic        en;
    logic        lvl;
    logic        tone;
    logic        dt;
    logic [1:0]  strap;
    lnbc_diag_t  diag;
    lnbc_core_t  core;
    wire logic   scl, hsda, sda_oe, sda_o, det, f_o, f_oe;
    wire logic   sda = hsda & ~(sda_oe & ~sda_o);
    logic [11:0] exp_q[$];
    logic [6:0]  adr[4] = '{7'h08, 7'h09, 7'h10, 7'h11};
    int          bad_count = 0;
    int          n_compared = 0;
    lnbc_top uut (.CLOCK(CLOCK), .RST(RST), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE(sda_oe),
        .ADDR_STRAP(strap), .ENABLE_PIN(en), .LEVEL_SELECT_PIN(lvl), .TONE_ACTIVE(tone),
        .DETECT_TONE_IN(dt), .DIAG_IN(diag), .CORE_OUT(core), .DETECT_OUT(det), .FAULT_OUT(f_o),
        .FAULT_OE(f_oe));
    lnbc_host h (.scl(scl), .sda_drv(hsda), .sda(sda));
    initial begin
        forever #5 CLOCK = ~CLOCK;
    end
    // expected core word; pin mode takes level and enable from the pins
    function automatic logic [11:0] ecore(input logic [7:0] a, b);
        return {a[6], a[7] ? a[4:1] : (lvl ? PIN_LEVEL_HIGH : PIN_LEVEL_LOW), a[0], b[7:4],
                a[7] ? b[3] : en, b[1] ? tone : b[0]};
    endfunction
    task automatic check(input logic [11:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // strap is held across the release so the target latches it cleanly
    task automatic do_reset(input logic [1:0] s);
        @(posedge CLOCK);
        RST <= 1'b1;
        strap <= s;
        tone <= 1'b0;
        dt <= 1'b0;
        diag <= '0;
        repeat (5) @(posedge CLOCK);
        RST <= 1'b0;
        repeat (6) @(posedge CLOCK);
    endtask
    task automatic wrx(input logic [6:0] a, input logic [7:0] i, d, input logic ok);
        repeat (3) exp_q.push_back({11'h000, !ok});
        // bus pins move two ns after a low clock edge, never on a sampling edge
        @(negedge CLOCK);
        #2;
        h.cond(1'b1);
        h.byt({a, 1'b0}, 1'b0);
        h.byt(i, 1'b0);
        h.byt(d, 1'b0);
        h.cond(1'b0);
    endtask
    task automatic rdx(input logic [6:0] a, input logic [7:0] i, e);
        repeat (3) exp_q.push_back(12'h000);
        exp_q.push_back({4'h0, e});
        @(negedge CLOCK);
        #2;
        h.cond(1'b1);
        h.byt({a, 1'b0}, 1'b0);
        h.byt(i, 1'b0);
        h.cond(1'b1);
        h.byt({a, 1'b1}, 1'b0);
        h.byt(8'hFF, 1'b1);
        h.cond(1'b0);
    endtask
    // acknowledges and read bytes are matched in order
    always @(h.got) begin
        check({4'h0, h.rd}, exp_q.pop_front());
    end
    initial begin
        repeat (90000) @(posedge CLOCK);
        bad_count++;
        close_out();
    end
    initial begin
        logic [7:0] d, c1, c2;
        logic [6:0] a, dv;
        logic [6:0] bad[3];
        void'($urandom(36));
        // every strap code after a fresh reset, pin mode, wrong targets refused
        for (int s = 0; s < 4; s++) begin
            en <= s != 0;
            lvl <= s[0];
            do_reset(2'(s));
            a = adr[s];
            d = (8'($urandom) & 8'hFB) | 8'h08;
            c2 = en ? d : 8'h09;
            bad = '{a ^ 7'h01, 7'h00, 7'h78};
            foreach (bad[k]) wrx(bad[k], 8'h01, d, 1'b0);
            check(core, ecore(8'h08, 8'h09));
            rdx(a, 8'h00, 8'h08);
            wrx(a, 8'h01, d, 1'b1);
            check(core, ecore(8'h08, c2));
            rdx(a, 8'h01, c2);
        end
        // register control through every level code; one pass with a slow controller
        for (int i = 0; i < 16; i++) begin
            c1 = {1'b1, 2'($urandom), 4'(i), 1'($urandom)};
            d = 8'($urandom) & 8'hFB;
            h.slow = (i == 5) ? 300 : 0;
            @(posedge CLOCK);
            tone <= 1'($urandom);
            dt <= 1'($urandom);
            wrx(a, 8'h00, c1, 1'b1);
            wrx(a, 8'h01, d, 1'b1);
            check(core, ecore(c1, d));
            check({11'h000, det}, {11'h000, !dt});
            rdx(a, 8'h00, c1);
            rdx(a, 8'h01, d);
        end
        @(posedge CLOCK);
        en <= 1'b0;
        repeat (6) @(posedge CLOCK);
        check(core, ecore(c1, d));
        rdx(a, 8'h05, 8'h00);
        // each fault flag: alert, latch beyond the condition, release by a status read
        for (int f = 0; f < 2; f++) begin
            dv = 7'($urandom) & 7'h73;
            @(posedge CLOCK);
            diag <= dv | (f ? 7'h04 : 7'h08);
            repeat (10) @(posedge CLOCK);
            check({11'h000, f_oe}, 12'h001);
            diag <= dv;
            repeat (10) @(posedge CLOCK);
            check({11'h000, f_oe}, 12'h001);
            wrx(a, 8'h02, 8'hFF, 1'b1);
            rdx(a, 8'h02, {1'b0, dv | (f ? 7'h04 : 7'h08)});
            check({11'h000, f_oe}, 12'h000);
            rdx(a, 8'h02, {1'b0, dv});
        end
        close_out();
    end
endmodule
bind lnbc_top lnbc_top_sva chk (.CLOCK, .RST, .SCL_IN, .SDA_OUT, .SDA_OE, .DETECT_TONE_IN, .DETECT_OUT,
    .DIAG_IN, .CORE_OUT, .FAULT_OUT, .FAULT_OE);
`default_nettype wire
